// ===== hw/status_byte_pkg.sv
// Shared constants and carrier types for the status byte encoder
`default_nettype none
package status_byte_pkg;
    // Timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int TICK_PERIOD_NS  = 1_000_000_000;
    localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STALE_TIME_S    = 10;
    localparam int STATIC_TIME_S   = 60;
    localparam int AVG_LONG_S      = 10;
    localparam int TIMER_W         = 8;
    localparam int TICK_W          = 27;

    // Fill code
    localparam int FILL_W          = 3;
    localparam int FILL_STEPS      = 8;
    localparam int FILL_FRAC_SHIFT = 3;

    // General status byte layout
    localparam int GEN_MALF_BIT    = 0;
    localparam int GEN_FILL_LSB    = 1;
    localparam int GEN_STATIC_BIT  = 5;
    localparam int GEN_HCRIT_BIT   = 6;
    localparam int GEN_HON_BIT     = 7;

    // Interpreter operating status layout
    localparam int OPS_FILL_LSB    = 1;
    localparam int OPS_HCRIT_BIT   = 5;
    localparam int OPS_HON_BIT     = 6;

    // Interpreter error status layout
    localparam int ERR_MALF_BIT    = 0;
    localparam int ERR_STATIC_BIT  = 1;

    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef struct packed {
        logic [7:0] general_status_byte;
        logic [7:0] interpreter_operating_status;
        logic [7:0] interpreter_error_status;
    } status_bytes_s;

    typedef struct packed {
        logic [TIMER_W-1:0] count;
        logic               expired;
    } timer_state_s;
endpackage
`default_nettype wire

// ===== hw/persistence_timer.sv
// Counts whole one-second ticks while a condition holds; flags once the limit is reached
`default_nettype none
module persistence_timer #(
    parameter int LIMIT = 10
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Condition
    input  wire logic tick_i,
    input  wire logic hold_i,
    output logic      expired_o
);
    localparam logic [status_byte_pkg::TIMER_W-1:0] LIMIT_C = status_byte_pkg::TIMER_W'(LIMIT);

    status_byte_pkg::timer_state_s st_r;
    status_byte_pkg::timer_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!hold_i) begin
            st_nxt.count = '0;
        end else if (tick_i && (st_r.count != LIMIT_C)) begin
            // Saturates so a lasting fault never wraps back to healthy
            st_nxt.count = st_r.count + 1'b1;
        end
        st_nxt.expired = hold_i && (st_nxt.count == LIMIT_C);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign expired_o = st_r.expired;
endmodule
`default_nettype wire

// ===== hw/fill_code_encoder.sv
// Maps averaging-buffer occupancy onto an eighths code
`default_nettype none
module fill_code_encoder #(
    parameter int CNT_W = 16
) (
    // Occupancy
    input  wire logic [CNT_W-1:0]                   count_i,
    input  wire logic [CNT_W-1:0]                   depth_i,
    output logic      [status_byte_pkg::FILL_W-1:0] code_o
);
    localparam int EXT_W = CNT_W + status_byte_pkg::FILL_FRAC_SHIFT;

    logic [EXT_W-1:0] scaled;

    always_comb begin
        scaled = {count_i, {status_byte_pkg::FILL_FRAC_SHIFT{1'b0}}};
        code_o = '0;
        // Code n once count/depth exceeds n/8; highest passing step wins
        for (int n = 1; n < status_byte_pkg::FILL_STEPS; n++) begin
            if (scaled > (EXT_W'(n) * EXT_W'(depth_i))) begin
                code_o = status_byte_pkg::FILL_W'(n);
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/status_byte_encoder.sv
// Builds the general, operating and error status bytes from measurement and heating state
`default_nettype none
// What this block does
// - General byte: malfunction b0, fill b1-3, zero b4, static b5, criterion b6, heating b7.
// - Averaging under ten seconds: malfunction after ten seconds without a new value.
// - Averaging ten seconds or more: malfunction when buffer holds under half expected values.
// - Fill code n means occupancy above n/8 up to (n+1)/8.
// - Static malfunction once a persistent fault lasts longer than one minute.
// - Heating criterion bit follows the current switch-on condition.
// - Heating-on bit follows the actual heating output.
// - Operating byte: zero b0, fill b1-3, zero b4, criterion b5, heating b6, zero b7.
// - Error byte: general malfunction b0, static malfunction b1, upper bits zero.
module status_byte_encoder #(
    parameter int CNT_W       = 16,
    parameter int AVG_W       = 16,
    parameter int TICK_CYCLES = status_byte_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Measurement state
    input  wire logic             new_value_i,
    input  wire logic [AVG_W-1:0] averaging_time_setting_i,
    input  wire logic [CNT_W-1:0] buffer_count_i,
    input  wire logic [CNT_W-1:0] buffer_depth_i,
    input  wire logic             virtual_temperature_fault_i,
    // Heating state
    input  wire logic             heat_criterion_i,
    input  wire logic             heating_on_i,
    // Status bytes
    output logic      [7:0]       general_status_byte_o,
    output logic      [7:0]       interpreter_operating_status_o,
    output logic      [7:0]       interpreter_error_status_o,
    output logic                  status_changed_o,
    output logic                  second_tick_o
);
    localparam int TICK_W = status_byte_pkg::TICK_W;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    typedef struct packed {
        status_byte_pkg::status_bytes_s bytes;
        logic                           changed;
        logic [TICK_W-1:0]              prescale;
        logic                           tick;
    } enc_state_s;

    enc_state_s st_r;
    enc_state_s st_nxt;

    logic [status_byte_pkg::FILL_W-1:0] fill_code;
    logic                               stale;
    logic                               static_fault;
    logic                               short_buffer;
    logic                               general_malf;
    logic                               persistent;

    fill_code_encoder #(
        .CNT_W(CNT_W)
    ) u_fill (
        .count_i (buffer_count_i),
        .depth_i (buffer_depth_i),
        .code_o  (fill_code)
    );

    // A value arriving clears the span; ten whole ticks without one means stale
    persistence_timer #(
        .LIMIT(status_byte_pkg::STALE_TIME_S)
    ) u_stale (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .tick_i    (st_r.tick),
        .hold_i    (!new_value_i),
        .expired_o (stale)
    );

    // One tick more than the span so the fault has lasted strictly over a minute
    persistence_timer #(
        .LIMIT(status_byte_pkg::STATIC_TIME_S + 1)
    ) u_static (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .tick_i    (st_r.tick),
        .hold_i    (persistent),
        .expired_o (static_fault)
    );

    always_comb begin
        st_nxt = st_r;

        // One-second prescaler shared by both timers
        st_nxt.tick = (st_r.prescale == TICK_LAST);
        if (st_nxt.tick) begin
            st_nxt.prescale = '0;
        end else begin
            st_nxt.prescale = st_r.prescale + 1'b1;
        end

        // Expected values at one per second equal the averaging time in seconds
        short_buffer = ((32'(buffer_count_i) << 1) < 32'(averaging_time_setting_i));
        if (32'(averaging_time_setting_i) < status_byte_pkg::AVG_LONG_S) begin
            general_malf = stale;
        end else begin
            general_malf = short_buffer;
        end
        // Losing measured values counts as a persistent fault as well
        persistent = virtual_temperature_fault_i || stale;

        st_nxt.bytes.general_status_byte = status_byte_pkg::STATUS_RESET;
        st_nxt.bytes.general_status_byte[status_byte_pkg::GEN_MALF_BIT] = general_malf;
        st_nxt.bytes.general_status_byte[status_byte_pkg::GEN_FILL_LSB +: status_byte_pkg::FILL_W] =
            fill_code;
        st_nxt.bytes.general_status_byte[status_byte_pkg::GEN_STATIC_BIT] = static_fault;
        st_nxt.bytes.general_status_byte[status_byte_pkg::GEN_HCRIT_BIT] = heat_criterion_i;
        st_nxt.bytes.general_status_byte[status_byte_pkg::GEN_HON_BIT] = heating_on_i;

        st_nxt.bytes.interpreter_operating_status = status_byte_pkg::STATUS_RESET;
        st_nxt.bytes.interpreter_operating_status[status_byte_pkg::OPS_FILL_LSB +: status_byte_pkg::FILL_W] =
            fill_code;
        st_nxt.bytes.interpreter_operating_status[status_byte_pkg::OPS_HCRIT_BIT] = heat_criterion_i;
        st_nxt.bytes.interpreter_operating_status[status_byte_pkg::OPS_HON_BIT] = heating_on_i;

        st_nxt.bytes.interpreter_error_status = status_byte_pkg::STATUS_RESET;
        st_nxt.bytes.interpreter_error_status[status_byte_pkg::ERR_MALF_BIT] = general_malf;
        st_nxt.bytes.interpreter_error_status[status_byte_pkg::ERR_STATIC_BIT] = static_fault;

        // Lets the telegram side resend only when something moved
        st_nxt.changed = (st_nxt.bytes != st_r.bytes);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign general_status_byte_o          = st_r.bytes.general_status_byte;
    assign interpreter_operating_status_o = st_r.bytes.interpreter_operating_status;
    assign interpreter_error_status_o     = st_r.bytes.interpreter_error_status;
    assign status_changed_o               = st_r.changed;
    assign second_tick_o                  = st_r.tick;
endmodule
`default_nettype wire

// ===== testbench/status_byte_encoder_props.sv
// Port-level assertions for the status byte encoder
`default_nettype none
module status_byte_checker #(
    parameter int CNT_W       = 16,
    parameter int AVG_W       = 16,
    parameter int TICK_CYCLES = status_byte_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic             clk_i,
    input wire logic             rst_b_i,
    // Inputs
    input wire logic             new_value_i,
    input wire logic [AVG_W-1:0] averaging_time_setting_i,
    input wire logic [CNT_W-1:0] buffer_count_i,
    input wire logic [CNT_W-1:0] buffer_depth_i,
    input wire logic             virtual_temperature_fault_i,
    input wire logic             heat_criterion_i,
    input wire logic             heating_on_i,
    // Outputs
    input wire logic [7:0]       general_status_byte_o,
    input wire logic [7:0]       interpreter_operating_status_o,
    input wire logic [7:0]       interpreter_error_status_o,
    input wire logic             status_changed_o,
    input wire logic             second_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [7:0]  gen = general_status_byte_o;
    wire logic [7:0]  ops = interpreter_operating_status_o;
    wire logic [7:0]  err = interpreter_error_status_o;
    wire logic [23:0] all_b = {gen, ops, err};
    wire logic        low = {buffer_count_i, 1'b0} < {1'b0, averaging_time_setting_i};
    wire logic        lng = averaging_time_setting_i >= AVG_W'(10);
    wire logic        full = buffer_count_i == buffer_depth_i && buffer_depth_i != '0;
    int               gap_r;
    // Negative until the first tick, so the uneven first period is not judged
    always_ff @(posedge clk_i) gap_r <= !rst_b_i ? -9 : second_tick_o ? 0 : gap_r < 0 ? gap_r : gap_r + 1;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_rst; !$past(rst_b_i) |-> all_b == 24'h0 && !status_changed_o && !second_tick_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_heat; $past(rst_b_i) |-> {gen[7:6], ops[6:5]} == {2{$past(heating_on_i), $past(heat_criterion_i)}};
    endproperty
    a_heat: assert property (p_heat) else $error("heating bits wrong");
    property p_rsv; {gen[4], ops[7], ops[4], ops[0], err[7:2]} == 10'h000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_fill; $past(rst_b_i) && $past(full) |-> gen[3:1] == 3'h7 && ops[3:1] == 3'h7; endproperty
    a_fill: assert property (p_fill) else $error("full buffer code wrong");
    property p_malf; $past(rst_b_i) && $past(lng) |-> gen[0] == $past(low); endproperty
    a_malf: assert property (p_malf) else $error("half-fill malfunction wrong");
    property p_err; err[1:0] == {gen[5], gen[0]}; endproperty
    a_err: assert property (p_err) else $error("error byte disagrees");
    // The change pulse is registered together with the bytes it announces
    property p_chg; $past(rst_b_i) |-> status_changed_o == (all_b != $past(all_b)); endproperty
    a_chg: assert property (p_chg) else $error("change pulse wrong");
    property p_tick; gap_r >= 0 |-> gap_r < TICK_CYCLES && second_tick_o == (gap_r == TICK_CYCLES - 1); endproperty
    a_tick: assert property (p_tick) else $error("tick period wrong");
    c_static: cover property (gen[5]);
    c_stale: cover property (gen[0] && !lng);
    c_chg: cover property (status_changed_o);
endmodule
bind status_byte_encoder status_byte_checker #(.CNT_W(CNT_W), .AVG_W(AVG_W), .TICK_CYCLES(TICK_CYCLES))
    status_byte_checker_i (.*);
`default_nettype wire

// ===== testbench/status_reader_model.sv
// Far-side reader that snapshots the bytes when they are announced as changed
`default_nettype none
module status_reader_model (
    // Clock
    input  wire logic                           clk_i,
    // Announcement and bytes
    input  wire logic                           changed_i,
    input  wire status_byte_pkg::status_bytes_s bytes_i,
    output var  status_byte_pkg::status_bytes_s seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Reads only on the pulse, so a missed pulse leaves a stale snapshot
    always_ff @(posedge clk_i) begin
        if (changed_i) begin
            seen_o <= bytes_i;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Random and directed checks of the status byte encoder
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH %0t %h", $time, a); end end
    localparam logic [15:0] CORNER [8] = '{16'h0000, 16'h0004, 16'h0005, 16'h0008, 16'h0009, 16'h0010, 16'h003F, 16'h0040};
    logic        clk_i = 1'b0, rst_b_i = 1'b0, nv = 1'b1, vt = 1'b0, hc = 1'b0, ho = 1'b0, chg, tick;
    logic [15:0] avg = 16'h000A, cnt = 16'h0000, dep = 16'h0040;
    logic [31:0] rnd = 32'hA3CFDA97;
    logic [7:0]  gen, ops, err;
    int          mismatches = 0, check_count = 0;
    status_byte_pkg::status_bytes_s seen;
    always #4 clk_i = ~clk_i;
    status_byte_encoder #(.TICK_CYCLES(4)) status_byte_encoder_i (.clk_i, .rst_b_i, .new_value_i(nv),
        .averaging_time_setting_i(avg), .buffer_count_i(cnt), .buffer_depth_i(dep), .virtual_temperature_fault_i(vt),
        .heat_criterion_i(hc), .heating_on_i(ho), .general_status_byte_o(gen), .interpreter_operating_status_o(ops),
        .interpreter_error_status_o(err), .status_changed_o(chg), .second_tick_o(tick));
    status_reader_model status_reader_model_i (.clk_i, .changed_i(chg), .bytes_i({gen, ops, err}), .seen_o(seen));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [23:0] expect_bytes();
        logic [2:0] f;
        logic       m;
        f = 3'h0;
        m = {cnt, 1'b0} < {1'b0, avg};
        for (int n = 1; n < 8; n++)
            if (8 * cnt > n * dep) f = 3'(n);
        return {ho, hc, 2'b00, f, m, 1'b0, ho, hc, 1'b0, f, 1'b0, 7'h00, m};
    endfunction
    task automatic ticks(int n);
        repeat (n) begin
            // Look after the edge that launched the tick, return on the edge whose timers consume it
            @(posedge clk_i);
            #1;
            while (tick !== 1'b1) begin
                @(posedge clk_i);
                #1;
            end
            @(posedge clk_i);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // Last reset edge: the first edge out of reset already loads live bytes
        #1 `CHK({gen, ops, err, chg, tick}, 26'h0)
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_i);
            rnd = lfsr(rnd);
            {hc, ho} <= rnd[1:0];
            if (i < 8) begin
                cnt <= CORNER[i];
            end else begin
                cnt <= {9'h000, rnd[22:16]};
                dep <= {8'h00, rnd[7:0]} | 16'h0080;
                avg <= {11'h000, rnd[12:8]} + 16'h000A;
            end
            @(posedge clk_i);
            #1 `CHK({gen, ops, err}, expect_bytes())
        end
        repeat (3) @(posedge clk_i);
        #1 `CHK(seen, {gen, ops, err})
        ticks(1);
        nv <= 1'b0;
        avg <= 16'h0005;
        ticks(9);
        #1 `CHK(gen[0], 1'b0)
        ticks(1);
        repeat (3) @(posedge clk_i);
        #1 `CHK({gen[0], err[0]}, 2'b11)
        @(posedge clk_i);
        nv <= 1'b1;
        ticks(2);
        vt <= 1'b1;
        ticks(60);
        #1 `CHK(gen[5], 1'b0)
        ticks(1);
        repeat (3) @(posedge clk_i);
        #1 `CHK({gen[5], err[1]}, 2'b11)
        @(posedge clk_i);
        hc <= 1'b1;
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 `CHK({gen, ops, err}, 24'h0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
